// *** rtl/pcstk_core.sv ***
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
module pcstk_core
    import pcstk_pkg::*;
(
    input  wire logic                     CLK,
    input  wire logic                     RST_N,
    input  wire logic                     HSEL,
    input  wire logic [31:0]              HADDR,
    input  wire logic [1:0]               HTRANS,
    input  wire logic                     HWRITE,
    input  wire logic [2:0]               HSIZE,
    input  wire logic [31:0]              HWDATA,
    input  wire logic                     HREADY,
    output logic      [31:0]              HRDATA,
    output logic                          HREADYOUT,
    output logic                          HRESP,
    input  wire pcstk_pkg::pcstk_req_type REQ,
    output logic      [12:0]              PC_OUT
);
    import pcstk_pkg::*;

    // port widths are fixed, so the package geometry must fit them
    if (PC_WIDTH != $bits(PC_OUT) || PC_WIDTH != LOW_WIDTH + UPPER_WIDTH ||
        PC_WIDTH != JUMP_WIDTH + 2 ||
        STACK_DEPTH != (1 << STACK_PTR_W)) begin : g_bad_geometry
        $error("program counter geometry does not fit the ports");
    end

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [PC_WIDTH-1:0]  pc_reg;
    logic [PC_WIDTH-1:0]  pc_next;
    logic [7:0]           pc_high_latch_reg;
    logic [7:0]           pc_high_latch_next;
    logic                 wr_pend_reg;
    logic [31:0]          wr_addr_reg;
    logic [31:0]          hrdata_reg;
    logic [31:0]          hrdata_next;
    logic                 hreadyout_reg;
    logic                 hresp_reg;

    ////////////////////////////////////////////////////////////////////////////
    // bus address phase decode

    logic addr_phase;
    logic rd_take;
    logic wr_take;
    logic hit_low;
    logic hit_latch;
    logic low_write;
    logic latch_write;

    assign addr_phase  = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
    assign rd_take     = addr_phase && !HWRITE;
    assign wr_take     = addr_phase && HWRITE && HSIZE == HSIZE_WORD;
    assign hit_low     = HADDR == ADDR_PC_LOW;
    assign hit_latch   = HADDR == ADDR_HIGH_LATCH;
    // writes land in the data phase, one cycle after the address phase
    assign low_write   = wr_pend_reg && wr_addr_reg == ADDR_PC_LOW;
    assign latch_write = wr_pend_reg && wr_addr_reg == ADDR_HIGH_LATCH;

    ////////////////////////////////////////////////////////////////////////////
    // read data: low byte and latch, upper counter bits never visible

    logic [7:0] latch_view;

    assign latch_view  = {3'h0, pc_high_latch_reg[LATCH_FIELD_W-1:0]};
    assign hrdata_next = !rd_take   ? hrdata_reg :
                         hit_low    ? {24'h0, pc_reg[LOW_WIDTH-1:0]} :
                         hit_latch  ? {24'h0, latch_view} :
                                      32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // decoder request

    logic          req_step;
    logic          req_jump;
    logic          req_call;
    logic          req_ret;
    logic          req_int;
    logic          req_add;
    logic [12:0]   pc_inc;
    logic [12:0]   far_target;
    logic [7:0]    low_sum;
    logic [12:0]   stack_top;
    logic          stack_push;
    logic          stack_pop;

    // one decode for every instruction kind, valid gates them all
    function automatic logic op_hit(input pcstk_req_type req, input logic [2:0] code);
        return req.valid && (req.op == code);
    endfunction

    // instruction request yields to a bus write of the low byte
    assign req_step   = op_hit(REQ, OPC_STEP);
    assign req_jump   = op_hit(REQ, OPC_JUMP);
    assign req_call   = op_hit(REQ, OPC_CALL);
    assign req_ret    = op_hit(REQ, OPC_RETURN);
    assign req_int    = op_hit(REQ, OPC_INT);
    assign req_add    = op_hit(REQ, OPC_ADD_LOW);

    assign pc_inc     = pc_reg + 13'h0001;
    // top two bits from the latch, eleven from the operand
    assign far_target = {pc_high_latch_reg[4:LATCH_TOP_LSB], REQ.target};
    // sum kept in eight bits, carry is dropped on purpose
    assign low_sum    = pc_reg[7:0] + REQ.offset;

    // return address is the counter plus one, the instruction after the one being left
    assign stack_push = !low_write && (req_call || req_int);
    assign stack_pop  = !low_write && !stack_push && req_ret;

    ////////////////////////////////////////////////////////////////////////////
    // next program counter

    always_comb begin
        pc_next = pc_reg;
        if (low_write) begin
            // whole five latch bits join the written byte
            pc_next = {pc_high_latch_reg[UPPER_WIDTH-1:0], HWDATA[7:0]};
        end else if (req_int) begin
            pc_next = INT_VECTOR;
        end else if (req_call || req_jump) begin
            pc_next = far_target;
        end else if (req_ret) begin
            pc_next = stack_top;
        end else if (req_add) begin
            pc_next = {pc_reg[12:8], low_sum};
        end else if (req_step) begin
            pc_next = pc_inc;
        end
    end

    // latch changes only by software, never by stack traffic
    assign pc_high_latch_next = latch_write ? {3'h0, HWDATA[4:0]} : pc_high_latch_reg;

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // any reset clears the counter
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pc_reg            <= PC_RESET;
            pc_high_latch_reg <= HIGH_LATCH_RESET;
        end else begin
            pc_reg            <= pc_next;
            pc_high_latch_reg <= pc_high_latch_next;
        end
    end

    // bus pipeline
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_reg   <= 1'b0;
            wr_addr_reg   <= 32'h0000_0000;
            hrdata_reg    <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            wr_pend_reg   <= wr_take;
            wr_addr_reg   <= wr_take ? HADDR : wr_addr_reg;
            hrdata_reg    <= hrdata_next;
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    // zero wait states, always OKAY; kept in flops so every output is registered
    assign HREADYOUT = hreadyout_reg;
    assign HRESP     = hresp_reg;
    assign HRDATA    = hrdata_reg;
    assign PC_OUT    = pc_reg;

    ////////////////////////////////////////////////////////////////////////////
    // return stack

    pcstk_stack #(
        .DEPTH (STACK_DEPTH),
        .WIDTH (PC_WIDTH),
        .PTR_W (STACK_PTR_W)
    ) u_stack (
        .clk       (CLK),
        .rst_n     (RST_N),
        .push      (stack_push),
        .pop       (stack_pop),
        .push_data (pc_inc),
        .top_data  (stack_top)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    low_write_load_a: assert property (@(posedge CLK) disable iff (!RST_N)
        low_write |=> pc_reg == {$past(pc_high_latch_reg[4:0]), $past(HWDATA[7:0])})
        else $error("low byte write did not load latch bits");

    far_load_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!low_write && !req_int && (req_call || req_jump))
        |=> pc_reg == {$past(pc_high_latch_reg[4:3]), $past(REQ.target)})
        else $error("call or jump target wrong");

    add_no_carry_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!low_write && req_add && !req_int && !req_call && !req_jump && !req_ret)
        |=> pc_reg[12:8] == $past(pc_reg[12:8]))
        else $error("computed jump carried into upper bits");

    int_vector_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!low_write && req_int) |=> pc_reg == INT_VECTOR)
        else $error("interrupt did not load vector");

    call_return_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (stack_push && req_call) ##1 (stack_pop && !low_write)
        |=> pc_reg == $past(pc_inc, 2))
        else $error("return did not restore pushed address");

    latch_stable_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!latch_write && (stack_push || stack_pop)) |=> $stable(pc_high_latch_reg))
        else $error("stack traffic changed the latch");

    read_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (rd_take && hit_low) |=> HRDATA == {24'h0, $past(pc_reg[7:0])})
        else $error("low byte read wrong");

    read_upper_hidden_a: assert property (@(posedge CLK) disable iff (!RST_N)
        rd_take |=> HRDATA[31:8] == 24'h0)
        else $error("upper bits leaked on read");

    ////////////////////////////////////////////////////////////////////////////
    // checks: counter stepping and loading

    // one step is a plain thirteen bit increment, wrapping at the top
    step_inc_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!low_write && req_step) |=> pc_reg == $past(pc_reg) + 13'h0001)
        else $error("step did not advance the counter");

    far_low_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!low_write && !req_int && (req_call || req_jump))
        |=> pc_reg[10:0] == $past(REQ.target))
        else $error("call or jump low bits not from operand");

    add_low_sum_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!low_write && req_add)
        |=> pc_reg[7:0] == 8'($past(pc_reg[7:0]) + $past(REQ.offset)))
        else $error("computed jump low byte wrong");

    // with nothing asked and no write, the counter holds
    idle_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (!low_write && !REQ.valid) |=> $stable(pc_reg))
        else $error("counter moved with no request");

    // checked while reset is low, so it carries no disable
    reset_clear_a: assert property (@(posedge CLK)
        !RST_N |-> (pc_reg == PC_RESET) && (pc_high_latch_reg == HIGH_LATCH_RESET))
        else $error("reset left the counter or latch set");

    // a low byte write wins the edge over any instruction
    write_wins_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (low_write && REQ.valid) |=> pc_reg[7:0] == $past(HWDATA[7:0]))
        else $error("instruction overrode a low byte write");

    return_pop_a: assert property (@(posedge CLK) disable iff (!RST_N)
        stack_pop |=> pc_reg == $past(stack_top))
        else $error("return did not load the stack top");

    ////////////////////////////////////////////////////////////////////////////
    // checks: register bus

    latch_write_a: assert property (@(posedge CLK) disable iff (!RST_N)
        latch_write |=> pc_high_latch_reg == {3'h0, $past(HWDATA[4:0])})
        else $error("latch did not take the written bits");

    latch_upper_zero_a: assert property (@(posedge CLK) disable iff (!RST_N)
        pc_high_latch_reg[7:5] == 3'h0)
        else $error("latch holds bits above its field");

    read_latch_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (rd_take && hit_latch) |=> HRDATA == {27'h0, $past(pc_high_latch_reg[4:0])})
        else $error("latch read wrong");

    unmapped_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
        (rd_take && !hit_low && !hit_latch) |=> HRDATA == 32'h0000_0000)
        else $error("unmapped read returned data");

    // read data stands until the next read address phase
    hrdata_stands_a: assert property (@(posedge CLK) disable iff (!RST_N)
        !rd_take |=> $stable(HRDATA))
        else $error("read data changed with no read");

endmodule // pcstk_core

// *** rtl/pcstk_pkg.sv ***
package pcstk_pkg;

    // program counter and stack geometry
    localparam int PC_WIDTH      = 13;
    localparam int LOW_WIDTH     = 8;
    localparam int UPPER_WIDTH   = 5;
    localparam int JUMP_WIDTH    = 11;
    localparam int STACK_DEPTH   = 8;
    localparam int STACK_PTR_W   = 3;

    // register byte addresses: printed offsets 0x02 and 0x0a are not multiples of four
    localparam logic [7:0]  IDX_PC_LOW     = 8'h02;
    localparam logic [7:0]  IDX_HIGH_LATCH = 8'h0A;
    localparam logic [31:0] ADDR_PC_LOW     = 32'h0000_0008;
    localparam logic [31:0] ADDR_HIGH_LATCH = 32'h0000_0028;

    // reset values
    localparam logic [12:0] PC_RESET        = 13'h0000;
    localparam logic [7:0]  HIGH_LATCH_RESET = 8'h00;

    // interrupt vector and latch field positions
    localparam logic [12:0] INT_VECTOR      = 13'h0004;
    localparam int          LATCH_TOP_LSB   = 3;
    localparam int          LATCH_FIELD_W   = 5;

    // ahb-lite codes
    localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
    localparam logic [2:0]  HSIZE_WORD      = 3'h2;

    // what the decoder asks of the counter in one instruction cycle
    typedef enum {
        PCSTK_OP_NONE,
        PCSTK_OP_STEP,
        PCSTK_OP_JUMP,
        PCSTK_OP_CALL,
        PCSTK_OP_RETURN,
        PCSTK_OP_INT,
        PCSTK_OP_ADD_LOW
    } pcstk_op_type;

    // decoder request carried as one bundle
    typedef struct packed {
        logic        valid;
        logic [2:0]  op;
        logic [10:0] target;
        logic [7:0]  offset;
    } pcstk_req_type;

    localparam logic [2:0] OPC_STEP    = 3'h1;
    localparam logic [2:0] OPC_JUMP    = 3'h2;
    localparam logic [2:0] OPC_CALL    = 3'h3;
    localparam logic [2:0] OPC_RETURN  = 3'h4;
    localparam logic [2:0] OPC_INT     = 3'h5;
    localparam logic [2:0] OPC_ADD_LOW = 3'h6;

endpackage

// *** rtl/pcstk_stack.sv ***
`timescale 1ns/1ps
// circular return stack, no pointer access and no overflow flag
module pcstk_stack #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 13,
    parameter int PTR_W = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             push,
    input  wire logic             pop,
    input  wire logic [WIDTH-1:0] push_data,
    output logic      [WIDTH-1:0] top_data
);
    import pcstk_pkg::*;

    // the ring wraps by pointer overflow, so depth must fill the pointer exactly
    if (DEPTH != (1 << PTR_W) || WIDTH < 1) begin : g_bad_depth
        $error("stack depth must equal two to the power of the pointer width");
    end

    logic [WIDTH-1:0] entry_reg [DEPTH];
    logic [PTR_W-1:0] ptr_reg;
    logic [PTR_W-1:0] ptr_next;
    logic [PTR_W-1:0] top_index;

    // pointer wraps silently both ways
    assign top_index = ptr_reg - PTR_W'(1);
    assign ptr_next  = push ? ptr_reg + PTR_W'(1) : (pop ? top_index : ptr_reg);
    assign top_data  = entry_reg[top_index];

    // storage held only here, off both address spaces
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_reg <= '0;
        end else begin
            ptr_reg <= ptr_next;
        end
    end

    // ninth push lands on the first slot again
    always_ff @(posedge clk) begin
        if (push) begin
            entry_reg[ptr_reg] <= push_data;
        end
    end

    stack_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
        push |=> ptr_reg == $past(ptr_reg) + PTR_W'(1))
        else $error("stack pointer did not advance on push");

    stack_pop_a: assert property (@(posedge clk) disable iff (!rst_n)
        (pop && !push) |=> ptr_reg == $past(ptr_reg) - PTR_W'(1))
        else $error("stack pointer did not step back on pop");

    push_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        push |=> entry_reg[$past(ptr_reg)] == $past(push_data))
        else $error("pushed value not stored");

endmodule // pcstk_stack

// *** bench/pcstk_decoder_model.sv ***
`timescale 1ns/1ps
// stands in for the instruction decoder: one request for each issued instruction
module pcstk_decoder_model (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     go,
    input  wire logic [2:0]               op,
    input  wire logic [10:0]              target,
    input  wire logic [7:0]               offset,
    output pcstk_pkg::pcstk_req_type      req
);
    import pcstk_pkg::*;

    // idle fields toggle so a stale operand never looks live
    // offsets wrap inside the page, table code must stay inside it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            req <= '0;
        end else if (go) begin
            req <= {1'b1, op, target, offset};
        end else begin
            req <= {1'b0, ~req.op, ~req.target, ~req.offset};
        end
    end
endmodule // pcstk_decoder_model

// *** bench/program_counter_and_call_stack_tb.sv ***
`timescale 1ns/1ps
module program_counter_and_call_stack_tb;
    import pcstk_pkg::*;

    logic          clk, rst_n, hsel, hwrite, go, hreadyout, hresp;
    logic [31:0]   haddr, hwdata, hrdata, rd;
    logic [1:0]    htrans;
    logic [2:0]    hsize, op;
    logic [10:0]   tgt;
    logic [7:0]    ofs, latch;
    logic [12:0]   pc_out, exp_pc;
    logic [12:0]   stk [8];
    logic [2:0]    sp;
    pcstk_req_type req;
    int            n_errors = 0, checks_done = 0, cycles = 0;

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    pcstk_core dut_u (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
        .HREADYOUT(hreadyout), .HRESP(hresp), .REQ(req), .PC_OUT(pc_out));
    pcstk_decoder_model dec_u (.clk(clk), .rst_n(rst_n), .go(go), .op(op), .target(tgt),
        .offset(ofs), .req(req));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // single word transfer, waits on ready in both phases
    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        @(posedge clk);
        hsel <= 1'b1; htrans <= HTRANS_NONSEQ; haddr <= addr; hwrite <= wr; hsize <= HSIZE_WORD;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= data;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, 32'h0);
        hsel <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        bus(1'b1, addr, data);
        if (addr == ADDR_HIGH_LATCH) latch = {3'h0, data[4:0]};
        if (addr == ADDR_PC_LOW) exp_pc = {latch[4:0], data[7:0]};
        chk(pc_out, exp_pc);
    endtask

    task automatic rdchk(input logic [31:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0);
        chk(rd, exp);
    endtask

    // issue one instruction through the decoder model and track the expected counter
    task automatic instr(input logic [2:0] o, input logic [10:0] t, input logic [7:0] f);
        @(posedge clk);
        go <= 1'b1; op <= o; tgt <= t; ofs <= f;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        case (o)
            OPC_STEP:    exp_pc = exp_pc + 13'h1;
            OPC_JUMP:    exp_pc = {latch[4:3], t};
            OPC_CALL:    begin
                stk[sp] = exp_pc + 13'h1; sp = sp + 3'h1; exp_pc = {latch[4:3], t};
            end
            OPC_RETURN:  begin
                sp = sp - 3'h1; exp_pc = stk[sp];
            end
            OPC_INT:     begin
                stk[sp] = exp_pc + 13'h1; sp = sp + 3'h1; exp_pc = INT_VECTOR;
            end
            OPC_ADD_LOW: exp_pc[7:0] = exp_pc[7:0] + f;
            default:     exp_pc = exp_pc;
        endcase
        chk(pc_out, exp_pc);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // hang guard, far above the some 130 cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("unexpected at %0t: run timed out", $time);
            complete_run;
        end
    end

    initial begin
        rst_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0; hsize = '0;
        hwdata = '0; go = 1'b0; op = '0; tgt = '0; ofs = '0; exp_pc = '0; sp = '0; latch = '0;
        repeat (8) @(posedge clk);
        chk(pc_out, 13'h0);
        rst_n <= 1'b1;
        rdchk(ADDR_PC_LOW, 32'h0);
        rdchk(ADDR_HIGH_LATCH, 32'h0);
        rdchk(32'h0000_0010, 32'h0);
        wr(ADDR_HIGH_LATCH, 32'hFFFF_FFFF);
        rdchk(ADDR_HIGH_LATCH, 32'h1F);
        wr(ADDR_PC_LOW, 32'h0000_00FE);
        rdchk(ADDR_PC_LOW, 32'hFE);
        instr(OPC_STEP, 11'h0, 8'h0);
        instr(OPC_STEP, 11'h0, 8'h0);
        wr(ADDR_PC_LOW, 32'h0000_0080);
        instr(OPC_ADD_LOW, 11'h0, 8'h90);
        wr(ADDR_HIGH_LATCH, 32'h0000_0015);
        instr(OPC_JUMP, 11'h7FF, 8'h0);
        // nine calls then an interrupt: the ring wraps with no flag
        for (int i = 0; i < 9; i++) begin
            instr(OPC_CALL, 11'(i * 64 + 3), 8'h0);
        end
        instr(OPC_INT, 11'h0, 8'h0);
        for (int i = 0; i < 10; i++) begin
            instr(OPC_RETURN, 11'h0, 8'h0);
        end
        rdchk(ADDR_HIGH_LATCH, 32'h15);
        // reset in mid-run clears the counter and the latch again
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(pc_out, 13'h0);
        exp_pc = '0; sp = '0; latch = '0;
        @(posedge clk);
        rst_n <= 1'b1;
        rdchk(ADDR_HIGH_LATCH, 32'h0);
        // low byte write and a call at one edge: the write wins, nothing is pushed
        fork
            bus(1'b1, ADDR_PC_LOW, 32'h0000_0040);
            begin
                @(posedge clk);
                go <= 1'b1; op <= OPC_CALL; tgt <= 11'h123;
                @(posedge clk);
                go <= 1'b0;
            end
        join
        exp_pc = {latch[4:0], 8'h40};
        chk(pc_out, exp_pc);
        // a pop now shows whether the refused call pushed anything
        instr(OPC_RETURN, 11'h0, 8'h0);
        instr(OPC_CALL, 11'h005, 8'h0);
        instr(OPC_RETURN, 11'h0, 8'h0);
        // call and return on consecutive edges
        @(posedge clk);
        go <= 1'b1; op <= OPC_CALL; tgt <= 11'h2AA;
        @(posedge clk);
        op <= OPC_RETURN;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
        stk[sp] = exp_pc + 13'h1;
        exp_pc = stk[sp];
        chk(pc_out, exp_pc);
        complete_run;
    end
endmodule // program_counter_and_call_stack_tb
